// File: include/dmacp_defs.svh
// Register indices, field positions and reset values.
// Assumes a 32-bit AXI4-Lite slave; byte address is four times the index.
`ifndef DMACP_DEFS_SVH
`define DMACP_DEFS_SVH

`define DMACP_AXI_ADDR_W      8
`define DMACP_IDX_LAST_CHAN   5'h0f
`define DMACP_IDX_CHCR0       5'h10
`define DMACP_IDX_PCR         5'h14
`define DMACP_IDX_ICR         5'h15
`define DMACP_IDX_DCR         5'h16
`define DMACP_IDX_EVT_STATUS  5'h18
`define DMACP_IDX_EVT_MASK    5'h19

`define DMACP_SEL_ADDR_HI     2'h0
`define DMACP_SEL_ADDR_LO     2'h1
`define DMACP_SEL_COUNT_HI    2'h2
`define DMACP_SEL_COUNT_LO    2'h3

`define DMACP_CHANNEL_CONTROL_DIR        0
`define DMACP_CHANNEL_CONTROL_BURST      1
`define DMACP_CHANNEL_CONTROL_FLOAT      2
`define DMACP_CHANNEL_CONTROL_DOWN       3
`define DMACP_CHANNEL_CONTROL_BUSY       6
`define DMACP_CHANNEL_CONTROL_DONE       7
`define DMACP_PCR_ROTATE      7
`define DMACP_ICR_FLAG        7

`define DMACP_RESET_BYTE      8'h00
`define DMACP_RESET_WORD      16'h0000
`define DMACP_COUNT_LAST      16'h0001

`define DMACP_RESP_OKAY       2'h0
`define DMACP_RESP_SLVERR     2'h2

`endif

// File: include/dmacp_pkg.sv
// Types used by the DMA channel controller top; the arbiter uses its own parameters.
// Assumes four channels selected by a two-bit index.
package dmacp_pkg;

  typedef logic [1:0] dmacp_chan_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_GRANT = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_HOLD  = 4'b1000
  } dmacp_state_e;

endpackage : dmacp_pkg

// File: rtl/dmacp_arbiter.sv
// Channel arbiter: fixed numerical order or rotating order by completion age.
// Assumes done_valid_in pulses once per finished block, in the clk_in domain.
`timescale 1ns/1ps
module dmacp_arbiter #(
  parameter int N  = 4,
  parameter int IW = 2
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          reset_in,
  // Requests and mode
  input  wire logic [N-1:0]  pending_in,
  input  wire logic          rotate_in,
  // Completion report
  input  wire logic          done_valid_in,
  input  wire logic [IW-1:0] done_chan_in,
  // Choice
  output logic               pick_valid_out,
  output logic [IW-1:0]      pick_chan_out
);

  if (N < 2 || (1 << IW) < N) begin : g_bad_size
    $error("dmacp_arbiter: IW too narrow for N");
  end

  // Position 0 holds the channel that finished longest ago
  logic [IW-1:0] order [N];
  logic [IW-1:0] done_pos;

  always_comb begin
    done_pos = '0;
    for (int i = 0; i < N; i++) begin
      if (order[i] == done_chan_in) begin
        done_pos = IW'(i);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < N; i++) begin
        order[i] <= IW'(i);
      end
    end else if (done_valid_in) begin
      // Finished channel moves to the back, ranking lowest
      for (int i = 0; i < N - 1; i++) begin
        if (IW'(i) >= done_pos) begin
          order[i] <= order[i + 1];
        end
      end
      order[N - 1] <= done_chan_in;
    end
  end

  always_comb begin
    pick_valid_out = |pending_in;
    pick_chan_out  = '0;
    if (rotate_in) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (pending_in[order[i]]) begin
          pick_chan_out = order[i];
        end
      end
    end else begin
      for (int i = N - 1; i >= 0; i--) begin
        if (pending_in[i]) begin
          pick_chan_out = IW'(i);
        end
      end
    end
  end

endmodule : dmacp_arbiter

// File: rtl/dmacp_top.sv
// Four-channel DMA control: channel registers, priority, request service and interrupts.
// Assumes an AXI4-Lite master on clk_in and peripherals synchronous to clk_in.
//
// How it works
// - Direction bit 1 drives rw high (memory read); 0 drives it low.
// - Burst bit 1 with method bit 0 holds the bus for the whole block; otherwise the bus is freed per byte.
// - Method bit 0 uses halt request; 1 uses clock stretch request.
// - Address steps down by one when down bit is 1, else up.
// - Busy flag sets on first request, clears when count reaches zero.
// - Block-end flag sets at block end, clears when control register is read.
// - Active-low interrupt is OR of block-end flags gated by enables.
// - Interrupt-control top bit mirrors the interrupt output, 1 while low.
// - Request-accept enable 0 ignores that channel's request and acknowledge.
// - Enable cleared mid-block stops service, keeping address and count.
// - Rotate bit 0 gives fixed priority, channel 0 first.
// - Rotate bit 1 ranks the longest-ago finished channel highest.
// - Unused register bits read as zero.
// - Byte count drops by one per byte; zero ends the block.
`timescale 1ns/1ps
`include "dmacp_defs.svh"
module dmacp_top #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Peripheral side
  input  wire logic [3:0]  transfer_request_in,
  output logic [3:0]       transfer_ack_out,
  output logic             block_done_out,
  // Processor bus side
  input  wire logic        bus_grant_in,
  output logic             halt_request_out,
  output logic             clock_stretch_request_out,
  output logic             rw_out,
  output logic [15:0]      address_out,
  // Interrupts
  output logic             irq_n_out,
  output logic             irq_out
);

  if (CHANNELS != 4) begin : g_bad_channels
    $error("dmacp_top: only four channels are served");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0]             address [4];
  logic [15:0]             byte_count [4];
  logic [3:0]              channel_control [4];
  logic [3:0]              busy;
  logic [3:0]              done;
  logic [3:0]              request_accept_enable;
  logic                    rotate;
  logic [3:0]              irq_enable;
  logic [3:0]              evt_status;
  logic [3:0]              evt_mask;
  dmacp_pkg::dmacp_state_e state;
  dmacp_pkg::dmacp_chan_t  cur;

  logic [3:0]              pending;
  logic                    pick_valid;
  dmacp_pkg::dmacp_chan_t  pick_chan;
  logic                    xfer_step;
  logic                    block_end;
  logic [3:0]              cur_onehot;

  function automatic logic [15:0] step_address(input logic [15:0] a, input logic down);
    step_address = down ? a - 16'h0001 : a + 16'h0001;
  endfunction : step_address

  function automatic logic is_mapped(input logic [7:0] byte_addr);
    logic [4:0] idx;
    idx = byte_addr[6:2];
    is_mapped = !byte_addr[7] && (idx <= `DMACP_IDX_DCR || idx == `DMACP_IDX_EVT_STATUS ||
                                  idx == `DMACP_IDX_EVT_MASK);
  endfunction : is_mapped

  // Count of zero never asks for service, so a stale request cannot wrap it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pending[i] = transfer_request_in[i] && request_accept_enable[i] &&
                   (byte_count[i] != `DMACP_RESET_WORD);
    end
  end

  assign xfer_step  = (state == dmacp_pkg::ST_XFER);
  assign block_end  = xfer_step && (byte_count[cur] == `DMACP_COUNT_LAST);
  assign cur_onehot = 4'h1 << cur;

  dmacp_arbiter #(
    .N  (4),
    .IW (2)
  ) u_arbiter (
    .clk_in         (clk_in),
    .reset_in       (reset_in),
    .pending_in     (pending),
    .rotate_in      (rotate),
    .done_valid_in  (block_end),
    .done_chan_in   (cur),
    .pick_valid_out (pick_valid),
    .pick_chan_out  (pick_chan)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes: one-cycle ready once the address (and, for writes, the data) waits

  logic       wr_fire;
  logic       rd_fire;
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic       wr_byte;

  assign wr_fire = s_axi_awready_out;
  assign rd_fire = s_axi_arready_out;
  assign wr_idx  = s_axi_awaddr_in[6:2];
  assign rd_idx  = s_axi_araddr_in[6:2];
  assign wr_byte = wr_fire && s_axi_wstrb_in[0] && is_mapped(s_axi_awaddr_in);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `DMACP_RESP_OKAY;
    end else begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      if (s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_awready_out && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= is_mapped(s_axi_awaddr_in) ? `DMACP_RESP_OKAY : `DMACP_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  logic [7:0] read_byte;

  always_comb begin
    read_byte = `DMACP_RESET_BYTE;
    if (rd_idx <= `DMACP_IDX_LAST_CHAN) begin
      unique case (rd_idx[1:0])
        `DMACP_SEL_ADDR_HI:  read_byte = address[rd_idx[3:2]][15:8];
        `DMACP_SEL_ADDR_LO:  read_byte = address[rd_idx[3:2]][7:0];
        `DMACP_SEL_COUNT_HI: read_byte = byte_count[rd_idx[3:2]][15:8];
        `DMACP_SEL_COUNT_LO: read_byte = byte_count[rd_idx[3:2]][7:0];
      endcase
    end else if (rd_idx < `DMACP_IDX_PCR) begin
      read_byte = {done[rd_idx[1:0]], busy[rd_idx[1:0]], 2'h0, channel_control[rd_idx[1:0]]};
    end else if (rd_idx == `DMACP_IDX_PCR) begin
      read_byte = {rotate, 3'h0, request_accept_enable};
    end else if (rd_idx == `DMACP_IDX_ICR) begin
      read_byte = {!irq_n_out, 3'h0, irq_enable};
    end else if (rd_idx == `DMACP_IDX_EVT_STATUS) begin
      read_byte = {4'h0, evt_status};
    end else if (rd_idx == `DMACP_IDX_EVT_MASK) begin
      read_byte = {4'h0, evt_mask};
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `DMACP_RESP_OKAY;
    end else begin
      s_axi_arready_out <= s_axi_arvalid_in && !s_axi_arready_out && !s_axi_rvalid_out;
      if (rd_fire) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= is_mapped(s_axi_araddr_in) ? {24'h00_0000, read_byte} : 32'h0000_0000;
        s_axi_rresp_out  <= is_mapped(s_axi_araddr_in) ? `DMACP_RESP_OKAY : `DMACP_RESP_SLVERR;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 4; i++) begin
        channel_control[i] <= 4'h0;
      end
      request_accept_enable <= 4'h0;
      rotate                <= 1'b0;
      irq_enable            <= 4'h0;
      evt_mask              <= 4'h0;
    end else if (wr_byte) begin
      if (wr_idx >= `DMACP_IDX_CHCR0 && wr_idx < `DMACP_IDX_PCR) begin
        channel_control[wr_idx[1:0]] <= s_axi_wdata_in[3:0];
      end
      if (wr_idx == `DMACP_IDX_PCR) begin
        request_accept_enable <= s_axi_wdata_in[3:0];
        rotate                <= s_axi_wdata_in[`DMACP_PCR_ROTATE];
      end
      if (wr_idx == `DMACP_IDX_ICR) begin
        irq_enable <= s_axi_wdata_in[3:0];
      end
      if (wr_idx == `DMACP_IDX_EVT_MASK) begin
        evt_mask <= s_axi_wdata_in[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and count; a software write in the step cycle wins

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 4; i++) begin
        address[i]    <= `DMACP_RESET_WORD;
        byte_count[i] <= `DMACP_RESET_WORD;
      end
    end else begin
      if (xfer_step) begin
        address[cur]    <= step_address(address[cur], channel_control[cur][`DMACP_CHANNEL_CONTROL_DOWN]);
        byte_count[cur] <= byte_count[cur] - 16'h0001;
      end
      if (wr_byte && wr_idx <= `DMACP_IDX_LAST_CHAN) begin
        unique case (wr_idx[1:0])
          `DMACP_SEL_ADDR_HI:  address[wr_idx[3:2]][15:8]    <= s_axi_wdata_in[7:0];
          `DMACP_SEL_ADDR_LO:  address[wr_idx[3:2]][7:0]     <= s_axi_wdata_in[7:0];
          `DMACP_SEL_COUNT_HI: byte_count[wr_idx[3:2]][15:8] <= s_axi_wdata_in[7:0];
          `DMACP_SEL_COUNT_LO: byte_count[wr_idx[3:2]][7:0]  <= s_axi_wdata_in[7:0];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; a block end wins over any other update of the same channel's flags in that cycle

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      busy       <= 4'h0;
      done       <= 4'h0;
      evt_status <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (block_end && cur == 2'(i)) begin
          busy[i]       <= 1'b0;
          done[i]       <= 1'b1;
          evt_status[i] <= 1'b1;
        end else begin
          if (pending[i]) begin
            busy[i] <= 1'b1;
          end
          if (rd_fire && is_mapped(s_axi_araddr_in) && rd_idx == `DMACP_IDX_CHCR0 + 5'(i)) begin
            done[i] <= 1'b0;
          end
          if (wr_byte && wr_idx == `DMACP_IDX_EVT_STATUS && s_axi_wdata_in[i]) begin
            evt_status[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_n_out <= 1'b1;
      irq_out   <= 1'b0;
    end else begin
      irq_n_out <= !(|(done & irq_enable));
      irq_out   <= |(evt_status & evt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service sequence

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state                     <= dmacp_pkg::ST_IDLE;
      cur                       <= 2'h0;
      halt_request_out          <= 1'b0;
      clock_stretch_request_out <= 1'b0;
      transfer_ack_out          <= 4'h0;
      block_done_out            <= 1'b0;
      rw_out                    <= 1'b0;
      address_out               <= `DMACP_RESET_WORD;
    end else begin
      unique case (state)
        dmacp_pkg::ST_IDLE: begin
          // Wait for the previous grant to fall before asking again
          if (pick_valid && !bus_grant_in) begin
            cur                       <= pick_chan;
            halt_request_out          <= !channel_control[pick_chan][`DMACP_CHANNEL_CONTROL_FLOAT];
            clock_stretch_request_out <= channel_control[pick_chan][`DMACP_CHANNEL_CONTROL_FLOAT];
            state                     <= dmacp_pkg::ST_GRANT;
          end
        end
        dmacp_pkg::ST_GRANT, dmacp_pkg::ST_HOLD: begin
          // A dropped request keeps the bus asked for until it returns
          if (!request_accept_enable[cur]) begin
            halt_request_out          <= 1'b0;
            clock_stretch_request_out <= 1'b0;
            state                     <= dmacp_pkg::ST_IDLE;
          end else if (pending[cur] && bus_grant_in) begin
            transfer_ack_out <= cur_onehot;
            block_done_out   <= (byte_count[cur] == `DMACP_COUNT_LAST);
            rw_out           <= channel_control[cur][`DMACP_CHANNEL_CONTROL_DIR];
            address_out      <= address[cur];
            state            <= dmacp_pkg::ST_XFER;
          end
        end
        dmacp_pkg::ST_XFER: begin
          transfer_ack_out <= 4'h0;
          block_done_out   <= 1'b0;
          // Bus float with burst is not served as burst: it would starve the clock
          if (!block_end && channel_control[cur][`DMACP_CHANNEL_CONTROL_BURST] &&
              !channel_control[cur][`DMACP_CHANNEL_CONTROL_FLOAT]) begin
            state <= dmacp_pkg::ST_HOLD;
          end else begin
            halt_request_out          <= 1'b0;
            clock_stretch_request_out <= 1'b0;
            state                     <= dmacp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule : dmacp_top

// File: verif/dmacp_periph_model.sv
// Peripheral controllers and processor bus release, as seen by the DMA block.
// Assumes requests are wanted by the bench; grant follows either bus request.
`timescale 1ns/1ps
module dmacp_periph_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // Bench control
  input  wire logic [3:0] want_in,
  input  wire logic       slow_in,
  // Device side
  input  wire logic [3:0] ack_in,
  input  wire logic       halt_in,
  input  wire logic       stretch_in,
  output logic      [3:0] request_out,
  output logic            grant_out
);
  logic [1:0] wait_cnt;
  //////////////////////////////////////////////////////////////
  // Each strobe ends the request, so a held want is a fresh request per byte
  always_ff @(posedge clk_in) begin
    if (reset_in)
      request_out <= 4'h0;
    else
      request_out <= want_in & ~ack_in;
  end
  // Slow mode models a processor that takes four cycles to let go
  always_ff @(posedge clk_in) begin
    if (reset_in || !(halt_in || stretch_in)) begin
      grant_out <= 1'b0;
      wait_cnt  <= 2'h0;
    end else if (wait_cnt == (slow_in ? 2'h3 : 2'h0))
      grant_out <= 1'b1;
    else
      wait_cnt <= wait_cnt + 2'h1;
  end
endmodule : dmacp_periph_model

// File: verif/dmacp_top_sva.sv
// Port assertions for the DMA channel controller top.
// Assumes one clk_in domain with synchronous active-high reset_in.
`timescale 1ns/1ps
module dmacp_top_sva (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // Watched ports
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [3:0]  transfer_request_in,
  input wire logic [3:0]  transfer_ack_out,
  input wire logic        block_done_out,
  input wire logic        bus_grant_in,
  input wire logic        halt_request_out,
  input wire logic        clock_stretch_request_out,
  input wire logic        irq_n_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  //////////////////////////////////////////////////////////////
  property p_ack_onehot; transfer_ack_out != 4'h0 |-> $onehot(transfer_ack_out); endproperty
  a_ack_onehot: assert property (p_ack_onehot) else $error("two channels acked at once");
  property p_ack_cause; transfer_ack_out != 4'h0 |-> (transfer_ack_out & ~$past(transfer_request_in)) == 4'h0;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_bus; transfer_ack_out != 4'h0 |-> $past(bus_grant_in) && (halt_request_out || clock_stretch_request_out);
  endproperty
  a_ack_bus: assert property (p_ack_bus) else $error("ack without bus");
  property p_one_method; !(halt_request_out && clock_stretch_request_out); endproperty
  a_one_method: assert property (p_one_method) else $error("both bus requests");
  property p_ask_cause; $rose(halt_request_out) || $rose(clock_stretch_request_out) |-> $past(transfer_request_in) != 4'h0;
  endproperty
  a_ask_cause: assert property (p_ask_cause) else $error("bus asked unrequested");
  property p_done_ack; block_done_out |-> $onehot(transfer_ack_out); endproperty
  a_done_ack: assert property (p_done_ack) else $error("block end without ack");
  property p_done_pulse; block_done_out |=> !block_done_out; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("block end held too long");
  property p_reset_out; $fell(reset_in) |-> irq_n_out && transfer_ack_out == 4'h0 && !halt_request_out; endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
  property p_rdata_pad; s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0; endproperty
  a_rdata_pad: assert property (p_rdata_pad) else $error("unused read bits not zero");
endmodule : dmacp_top_sva

bind dmacp_top dmacp_top_sva u_sva (
  .clk_in(clk_in), .reset_in(reset_in), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .transfer_request_in(transfer_request_in), .transfer_ack_out(transfer_ack_out), .block_done_out(block_done_out),
  .bus_grant_in(bus_grant_in), .halt_request_out(halt_request_out),
  .clock_stretch_request_out(clock_stretch_request_out), .irq_n_out(irq_n_out)
);

// File: verif/dmacp_top_tb_top.sv
// Self-checking bench: AXI4-Lite register access and DMA channel service.
// Assumes the peripheral model answers bus requests and strobes.
`timescale 1ns/1ps
`include "dmacp_defs.svh"
module dmacp_top_tb_top;
  localparam logic [4:0] i_ch = `DMACP_IDX_CHCR0;
  localparam logic [4:0] i_pc = `DMACP_IDX_PCR;
  localparam logic [4:0] i_ic = `DMACP_IDX_ICR;
  localparam logic [1:0] serr = `DMACP_RESP_SLVERR;
  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  awaddr   = 8'h00;
  logic [7:0]  araddr   = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic [3:0]  want     = 4'h0;
  logic        slow     = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, done, grant, halt, stretch, rw, irq_n, irq, halt_d;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  req, ack;
  logic [15:0] addr;
  logic [23:0] ack_q[$];
  int          err_count = 0;
  int          cmp_count = 0;
  int          drops     = 0;
  int          cycles    = 0;

  always #4 clk_in = ~clk_in;
  dmacp_top dut (
    .clk_in(clk_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .transfer_request_in(req), .transfer_ack_out(ack), .block_done_out(done), .bus_grant_in(grant),
    .halt_request_out(halt), .clock_stretch_request_out(stretch), .rw_out(rw), .address_out(addr),
    .irq_n_out(irq_n), .irq_out(irq)
  );
  dmacp_periph_model peer (
    .clk_in(clk_in), .reset_in(reset_in), .want_in(want), .slow_in(slow), .ack_in(ack),
    .halt_in(halt), .stretch_in(stretch), .request_out(req), .grant_out(grant)
  );
  //////////////////////////////////////////////////////////////
  // Byte log and halt releases; a release between bytes marks cycle steal
  always @(posedge clk_in) begin
    halt_d <= halt;
    if (!reset_in && halt_d === 1'b1 && halt === 1'b0) drops++;
    if (!reset_in && ack !== 4'h0) ack_q.push_back({done, rw, stretch, halt, ack, addr});
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic a_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge clk_in);
    awaddr  <= {1'b0, idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk_in);
      if (awready === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_in);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge clk_in);
    araddr  <= {1'b0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_in);
    chk(rdata, {24'h0, d});
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask : rd
  task automatic rd16(input logic [4:0] idx, input logic [15:0] v);
    rd(idx, v[15:8]);
    rd(idx + 5'h01, v[7:0]);
  endtask : rd16
  task automatic prog(input logic [1:0] ch, input logic [15:0] ad, input logic [15:0] n, input logic [7:0] c);
    logic [31:0] v = {ad, n};
    for (int k = 0; k < 4; k++) wr({1'b0, ch, k[1:0]}, v[31 - 8 * k -: 8]);
    wr(i_ch + {3'h0, ch}, c);
  endtask : prog
  // f: block end, direction, stretch; halt opposite stretch
  task automatic exp_ack(input logic [2:0] f, input logic [3:0] a, input logic [15:0] ad);
    while (ack_q.size() == 0) @(posedge clk_in);
    chk({8'h0, ack_q.pop_front()}, {8'h0, f, ~f[0], a, ad});
  endtask : exp_ack
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i < 4; i++) rd(i_ch + i[4:0], 8'h00);
    rd(i_pc, 8'h00);
    rd(i_ic, 8'h00);
    chk(32'(irq_n), 32'h1);
    rd(`DMACP_IDX_DCR, 8'h00);
    rd(5'h17, 8'h00, serr);
    wr(5'h17, 8'hff, serr);
    wr(i_ch, 8'hff);
    rd(i_ch, 8'h0f);
    wr(i_pc, 8'hff);
    rd(i_pc, 8'h8f);
    wr(i_ic, 8'hff);
    rd(i_ic, 8'h0f);
    // Cycle steal, memory to peripheral, counting up
    wr(i_pc, 8'h01);
    wr(i_ic, 8'h01);
    prog(2'h0, 16'h1234, 16'h0002, 8'h01);
    drops = 0;
    want <= 4'h1;
    exp_ack(3'h2, 4'h1, 16'h1234);
    exp_ack(3'h6, 4'h1, 16'h1235);
    want <= 4'h0;
    rd16(5'h00, 16'h1236);
    rd16(5'h02, 16'h0000);
    chk(drops, 2);
    chk(32'(irq_n), 32'h0);
    rd(i_ic, 8'h81);
    rd(`DMACP_IDX_EVT_STATUS, 8'h01);
    chk(32'(irq), 32'h0);
    wr(`DMACP_IDX_EVT_MASK, 8'h01);
    repeat (2) @(posedge clk_in);
    chk(32'(irq), 32'h1);
    wr(`DMACP_IDX_EVT_STATUS, 8'h01);
    rd(`DMACP_IDX_EVT_STATUS, 8'h00);
    chk(32'(irq), 32'h0);
    rd(i_ch, 8'h81);
    rd(i_ch, 8'h01);
    repeat (2) @(posedge clk_in);
    chk(32'(irq_n), 32'h1);
    // Bus float, peripheral to memory, counting down, slow grant, masked
    wr(i_pc, 8'h02);
    prog(2'h1, 16'h0100, 16'h0001, 8'h0c);
    slow <= 1'b1;
    want <= 4'h2;
    exp_ack(3'h5, 4'h2, 16'h0100);
    want <= 4'h0;
    slow <= 1'b0;
    rd16(5'h04, 16'h00ff);
    chk(32'(irq_n), 32'h1);
    rd(i_ch + 5'h01, 8'h8c);
    // Burst keeps the halt request through the block
    wr(i_pc, 8'h04);
    prog(2'h2, 16'h2000, 16'h0003, 8'h02);
    drops = 0;
    want <= 4'h4;
    exp_ack(3'h0, 4'h4, 16'h2000);
    exp_ack(3'h0, 4'h4, 16'h2001);
    exp_ack(3'h4, 4'h4, 16'h2002);
    want <= 4'h0;
    rd16(5'h0a, 16'h0000);
    chk(drops, 1);
    // Fixed order, then rotation ranking channel 1 as longest finished
    prog(2'h0, 16'h3000, 16'h0001, 8'h00);
    prog(2'h2, 16'h4000, 16'h0001, 8'h00);
    wr(i_pc, 8'h05);
    want <= 4'h5;
    exp_ack(3'h4, 4'h1, 16'h3000);
    exp_ack(3'h4, 4'h4, 16'h4000);
    want <= 4'h0;
    prog(2'h0, 16'h5000, 16'h0001, 8'h00);
    prog(2'h1, 16'h6000, 16'h0001, 8'h00);
    wr(i_pc, 8'h83);
    want <= 4'h3;
    exp_ack(3'h4, 4'h2, 16'h6000);
    exp_ack(3'h4, 4'h1, 16'h5000);
    want <= 4'h0;
    // Enable dropped mid-block: requests ignored, pointers frozen
    prog(2'h2, 16'h7000, 16'h0002, 8'h00);
    wr(i_pc, 8'h04);
    want <= 4'h4;
    while (ack[2] !== 1'b1) @(posedge clk_in);
    want <= 4'h0;
    exp_ack(3'h0, 4'h4, 16'h7000);
    wr(i_pc, 8'h00);
    rd(i_ch + 5'h02, 8'hc0);
    want <= 4'h4;
    repeat (20) @(posedge clk_in);
    chk(ack_q.size(), 0);
    rd16(5'h08, 16'h7001);
    rd16(5'h0a, 16'h0001);
    wr(i_pc, 8'h04);
    exp_ack(3'h4, 4'h4, 16'h7001);
    want <= 4'h0;
    close_out();
  end
endmodule : dmacp_top_tb_top
